// ==== design/ddcpc_pkg.sv ====
/*
  Register map, reset values and packed carriers of the preset bank.
  Assumes a 32-bit AXI4-Lite bus and one clock.
*/
package ddcpc_pkg;

  // Printed offsets are not all multiples of four, so they are register indices.
  localparam logic [9:0] IDX_Q_THRESH   = 10'h207;
  localparam logic [9:0] IDX_OVR_PERIOD = 10'h208;
  localparam logic [9:0] IDX_SRC_CTRL   = 10'h20c;
  localparam logic [9:0] IDX_PRESET_SEL = 10'h20d;
  localparam logic [9:0] IDX_RDIV       = 10'h20e;
  localparam logic [9:0] IDX_I_THRESH   = 10'h206;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h210;
  localparam logic [9:0] IDX_IRQ_MASK   = 10'h211;
  localparam logic [9:0] IDX_PRESET_WR  = 10'h212;
  localparam logic [9:0] IDX_ACTIVE     = 10'h213;
  localparam logic [9:0] IDX_FREQ_BASE  = 10'h220;
  localparam logic [9:0] IDX_PHASE_BASE = 10'h228;
  localparam logic [9:0] IDX_DELAY_BASE = 10'h230;

  localparam int ADDR_W   = 12;
  localparam int NPRESET  = 8;
  localparam int SAMPLE_W = 15;
  localparam int PER_W    = 3;
  localparam int PER_MAXW = 8;

  localparam logic [7:0]  RST_Q_THRESH = 8'hab;
  localparam logic [7:0]  RST_I_THRESH = 8'hf2;
  localparam logic [2:0]  RST_PER_EXP  = 3'h0;
  localparam logic        RST_SRC      = 1'h0;
  localparam logic [2:0]  RST_PRESET   = 3'h0;
  localparam logic [15:0] RST_RDIV     = 16'h0000;
  localparam logic [31:0] RST_FREQ     = 32'hc0000000;
  localparam logic [15:0] RST_PHASE    = 16'h0000;
  localparam logic [7:0]  RST_DELAY    = 8'hff;

  localparam int IRQ_W     = 3;
  localparam int IRQ_I_OVR = 0;
  localparam int IRQ_Q_OVR = 1;
  localparam int IRQ_PCHG  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [SAMPLE_W-1:0] i;
    logic [SAMPLE_W-1:0] q;
  } ddcpc_sample_t;

  typedef struct packed {
    logic [31:0] freq_word;
    logic [31:0] phase_word;
    logic [7:0]  delay;
  } ddcpc_preset_t;

  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic [7:0]  delay;
  } ddcpc_entry_t;

endpackage

// ==== design/ddcpc_preset_mem.sv ====
/*
  Eight-entry preset store: one write port, one registered read port.
  Assumes the writer runs on the same clock.
*/
`timescale 1ns/100ps
module ddcpc_preset_mem (
  input  wire logic                  aclk,    // clock
  input  wire logic                  aresetn, // sync reset, low
  input  wire logic                  wr_en,   // write strobe
  input  wire logic [2:0]            wr_idx,  // entry written
  input  wire ddcpc_pkg::ddcpc_entry_t wr_data, // entry value
  input  wire logic [2:0]            rd_idx,  // entry read
  output ddcpc_pkg::ddcpc_entry_t    rd_data  // registered entry
);

  ddcpc_pkg::ddcpc_entry_t mem_r [ddcpc_pkg::NPRESET];

  genvar g;
  generate
    for (g = 0; g < ddcpc_pkg::NPRESET; g++) begin : g_ent
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mem_r[g] <= '{ddcpc_pkg::RST_FREQ, ddcpc_pkg::RST_PHASE, ddcpc_pkg::RST_DELAY};
        end else if (wr_en && wr_idx == 3'(g)) begin
          mem_r[g] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= '{ddcpc_pkg::RST_FREQ, ddcpc_pkg::RST_PHASE, ddcpc_pkg::RST_DELAY};
    end else begin
      rd_data <= mem_r[rd_idx];
    end
  end

endmodule

// ==== design/ddcpc_ovr_mon.sv ====
/*
  Overrange monitor for one channel: flags a sample reaching the threshold
  and holds the flag for 2**exponent samples.
  Assumes two's-complement samples with a valid strobe.
*/
`timescale 1ns/100ps
module ddcpc_ovr_mon (
  input  wire logic                          aclk,      // clock
  input  wire logic                          aresetn,   // sync reset, low
  input  wire logic                          smp_valid, // sample strobe
  input  wire logic [ddcpc_pkg::SAMPLE_W-1:0] smp,      // signed sample
  input  wire logic [7:0]                    thresh,    // level / 256 of full scale
  input  wire logic [ddcpc_pkg::PER_W-1:0]   per_exp,   // period exponent
  output logic                               flag,      // held overrange flag
  output logic                               hit        // one-cycle detection pulse
);

  logic [ddcpc_pkg::SAMPLE_W-1:0] mag;
  logic [ddcpc_pkg::PER_MAXW-1:0] cnt_r;
  logic [ddcpc_pkg::PER_MAXW-1:0] per_len;
  logic                           det;

  // Top eight magnitude bits meet the threshold; the most negative code is full scale.
  always_comb begin
    mag = smp[ddcpc_pkg::SAMPLE_W-1] ? ~smp + 1'b1 : smp;
    det = smp_valid && (mag[ddcpc_pkg::SAMPLE_W-1] || mag[ddcpc_pkg::SAMPLE_W-2 -: 8] >= thresh);
    per_len = ddcpc_pkg::PER_MAXW'(1) << per_exp;
  end

  assign hit = det;

  // A detection restarts the window; the flag drops once a full window is clean.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      flag  <= 1'b0;
    end else if (det) begin
      cnt_r <= per_len - 1'b1;
      flag  <= 1'b1;
    end else if (smp_valid && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else if (smp_valid) begin
      flag <= 1'b0;
    end
  end

endmodule

// ==== design/ddcpc_top.sv ====
/*
  Preset and overrange configuration bank behind AXI4-Lite.
  Holds the thresholds and period, the preset source and index,
  the shared divisor and eight presets; drives the active preset
  and the overrange flags.
  Assumes asynchronous preset pins and samples on aclk.
*/
// Behaviour
// - Q overrange flag bit 1 sets when Q magnitude reaches the Q threshold.
// - Q threshold is level over 256 of full scale, reset 0xab.
// - Overrange monitoring period is scaled by two to the exponent field.
// - Source bit 0 selects pins, bit 1 selects the preset index register.
// - Eight presets each hold frequency word, phase offset and delay.
// - Preset index field only matters while the source bit is 1.
// - One 16-bit rational divisor, reset zero, shared by all presets.
// - I overrange flag bit 0 sets when I magnitude reaches I threshold.
// - Phase offset sits in the upper half of a 32-bit accumulator word.
`timescale 1ns/100ps
module ddcpc_top (
  input  wire logic                    aclk,            // 100 MHz clock
  input  wire logic                    aresetn,         // sync reset, low
  input  wire logic [ddcpc_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input  wire logic                    s_axi_awvalid,   // write address valid
  output logic                         s_axi_awready,   // write address ready
  input  wire logic [31:0]             s_axi_wdata,     // write data
  input  wire logic [3:0]              s_axi_wstrb,     // byte enables
  input  wire logic                    s_axi_wvalid,    // write data valid
  output logic                         s_axi_wready,    // write data ready
  output logic [1:0]                   s_axi_bresp,     // write response
  output logic                         s_axi_bvalid,    // write response valid
  input  wire logic                    s_axi_bready,    // write response ready
  input  wire logic [ddcpc_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input  wire logic                    s_axi_arvalid,   // read address valid
  output logic                         s_axi_arready,   // read address ready
  output logic [31:0]                  s_axi_rdata,     // read data
  output logic [1:0]                   s_axi_rresp,     // read response
  output logic                         s_axi_rvalid,    // read valid
  input  wire logic                    s_axi_rready,    // read ready
  input  wire logic [2:0]              preset_select_pins, // async preset pins
  input  wire logic                    smp_valid,       // sample strobe
  input  wire ddcpc_pkg::ddcpc_sample_t smp_in,         // I and Q samples
  output ddcpc_pkg::ddcpc_sample_t     smp_out,         // registered samples
  output logic [1:0]                   overrange_flags, // bit 1 Q, bit 0 I
  output logic                         smp_out_valid,   // output strobe
  output logic [2:0]                   active_preset,   // selected preset
  output ddcpc_pkg::ddcpc_preset_t     preset_cfg,      // active preset values
  output logic [15:0]                  rational_step_divisor, // shared divisor
  output logic                         irq              // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0]  q_thr_r;
  logic [7:0]  i_thr_r;
  logic [2:0]  per_exp_r;
  logic        src_r;
  logic [2:0]  pidx_r;
  logic [15:0] rdiv_r;
  logic [ddcpc_pkg::IRQ_W-1:0] sts_r;
  logic [ddcpc_pkg::IRQ_W-1:0] mask_r;
  logic [2:0]  wr_sel_r;
  logic [2:0]  pin_s1_r;
  logic [2:0]  pin_s2_r;
  logic [2:0]  act_r;
  logic [2:0]  act_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data latched independently.

  logic                     aw_hold_r;
  logic                     w_hold_r;
  logic [9:0]               aw_idx_r;
  logic [31:0]              wd_r;
  logic [3:0]               ws_r;
  logic                     wr_go;
  logic                     wr_ok;
  logic [ddcpc_pkg::IRQ_W-1:0] ev;

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_idx_r  <= '0;
      wd_r      <= '0;
      ws_r      <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[ddcpc_pkg::ADDR_W-1:2];
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wd_r     <= s_axi_wdata;
        ws_r     <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  logic in_freq;
  logic in_phase;
  logic in_delay;
  always_comb begin
    in_freq  = aw_idx_r[9:3] == ddcpc_pkg::IDX_FREQ_BASE[9:3];
    in_phase = aw_idx_r[9:3] == ddcpc_pkg::IDX_PHASE_BASE[9:3];
    in_delay = aw_idx_r[9:3] == ddcpc_pkg::IDX_DELAY_BASE[9:3];
    unique case (aw_idx_r)
      ddcpc_pkg::IDX_Q_THRESH, ddcpc_pkg::IDX_I_THRESH, ddcpc_pkg::IDX_OVR_PERIOD,
      ddcpc_pkg::IDX_SRC_CTRL, ddcpc_pkg::IDX_PRESET_SEL, ddcpc_pkg::IDX_RDIV,
      ddcpc_pkg::IDX_IRQ_STATUS, ddcpc_pkg::IDX_IRQ_MASK, ddcpc_pkg::IDX_PRESET_WR,
      ddcpc_pkg::IDX_ACTIVE: wr_ok = 1'b1;
      default: wr_ok = in_freq || in_phase || in_delay;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ddcpc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? ddcpc_pkg::RESP_OKAY : ddcpc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; only the low byte lane carries 8-bit fields.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_thr_r   <= ddcpc_pkg::RST_Q_THRESH;
      i_thr_r   <= ddcpc_pkg::RST_I_THRESH;
      per_exp_r <= ddcpc_pkg::RST_PER_EXP;
      src_r     <= ddcpc_pkg::RST_SRC;
      pidx_r    <= ddcpc_pkg::RST_PRESET;
      rdiv_r    <= ddcpc_pkg::RST_RDIV;
      mask_r    <= '0;
      wr_sel_r  <= '0;
    end else if (wr_go) begin
      if (ws_r[0]) begin
        unique case (aw_idx_r)
          ddcpc_pkg::IDX_Q_THRESH:   q_thr_r   <= wd_r[7:0];
          ddcpc_pkg::IDX_I_THRESH:   i_thr_r   <= wd_r[7:0];
          // Changing this while the link runs can shift the window phase.
          ddcpc_pkg::IDX_OVR_PERIOD: per_exp_r <= wd_r[2:0];
          ddcpc_pkg::IDX_SRC_CTRL:   src_r     <= wd_r[0];
          ddcpc_pkg::IDX_PRESET_SEL: pidx_r    <= wd_r[2:0];
          ddcpc_pkg::IDX_IRQ_MASK:   mask_r    <= wd_r[ddcpc_pkg::IRQ_W-1:0];
          ddcpc_pkg::IDX_PRESET_WR:  wr_sel_r  <= wd_r[2:0];
          default: ;
        endcase
      end
      if (aw_idx_r == ddcpc_pkg::IDX_RDIV) begin
        if (ws_r[0]) rdiv_r[7:0]  <= wd_r[7:0];
        if (ws_r[1]) rdiv_r[15:8] <= wd_r[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preset store: whole entry is read-modify-written from the shadow copy.

  ddcpc_pkg::ddcpc_entry_t ent_rd;
  ddcpc_pkg::ddcpc_entry_t shadow_r [ddcpc_pkg::NPRESET];
  ddcpc_pkg::ddcpc_entry_t ent_wr;
  logic [2:0]              ent_idx;
  logic                    ent_we;

  always_comb begin
    ent_idx = aw_idx_r[2:0];
    ent_we  = wr_go && (in_freq || in_phase || in_delay);
    ent_wr  = shadow_r[ent_idx];
    for (int b = 0; b < 4; b++) begin
      if (in_freq && ws_r[b]) ent_wr.freq[b*8 +: 8] = wd_r[b*8 +: 8];
    end
    for (int b = 0; b < 2; b++) begin
      if (in_phase && ws_r[b]) ent_wr.phase[b*8 +: 8] = wd_r[b*8 +: 8];
    end
    if (in_delay && ws_r[0]) ent_wr.delay = wd_r[7:0];
  end

  // A small shadow serves bus reads and byte merges without a second port.
  genvar g;
  generate
    for (g = 0; g < ddcpc_pkg::NPRESET; g++) begin : g_sh
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          shadow_r[g] <= '{ddcpc_pkg::RST_FREQ, ddcpc_pkg::RST_PHASE, ddcpc_pkg::RST_DELAY};
        end else if (ent_we && ent_idx == 3'(g)) begin
          shadow_r[g] <= ent_wr;
        end
      end
    end
  endgenerate

  ddcpc_preset_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (ent_we),
    .wr_idx  (ent_idx),
    .wr_data (ent_wr),
    .rd_idx  (act_r),
    .rd_data (ent_rd)
  );

  always_comb begin
    preset_cfg.freq_word  = ent_rd.freq;
    preset_cfg.phase_word = {ent_rd.phase, 16'h0000};
    preset_cfg.delay      = ent_rd.delay;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preset selection.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= preset_select_pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign act_nxt = src_r ? pidx_r : pin_s2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_r <= ddcpc_pkg::RST_PRESET;
    end else begin
      act_r <= act_nxt;
    end
  end

  assign active_preset         = act_r;
  assign rational_step_divisor = rdiv_r;

  ////////////////////////////////////////////////////////////////////////////
  // Overrange monitors and sample delay.

  logic hit_i;
  logic hit_q;

  ddcpc_ovr_mon u_ovr_i (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .smp_valid (smp_valid),
    .smp       (smp_in.i),
    .thresh    (i_thr_r),
    .per_exp   (per_exp_r),
    .flag      (overrange_flags[0]),
    .hit       (hit_i)
  );

  ddcpc_ovr_mon u_ovr_q (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .smp_valid (smp_valid),
    .smp       (smp_in.q),
    .thresh    (q_thr_r),
    .per_exp   (per_exp_r),
    .flag      (overrange_flags[1]),
    .hit       (hit_q)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_out       <= '0;
      smp_out_valid <= 1'b0;
    end else begin
      smp_out       <= smp_in;
      smp_out_valid <= smp_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over the clear-on-read.

  logic rd_sts;
  assign ev = {act_nxt != act_r, hit_q, hit_i};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_r <= '0;
    end else begin
      sts_r <= (rd_sts ? '0 : sts_r) | ev;
    end
  end

  assign irq = |(sts_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  logic [9:0]  ar_idx;
  logic [31:0] rd_val;
  logic        rd_ok;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_idx        = s_axi_araddr[ddcpc_pkg::ADDR_W-1:2];
  assign rd_sts        = s_axi_arvalid && s_axi_arready && ar_idx == ddcpc_pkg::IDX_IRQ_STATUS;

  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    unique case (ar_idx)
      ddcpc_pkg::IDX_Q_THRESH:   rd_val[7:0] = q_thr_r;
      ddcpc_pkg::IDX_I_THRESH:   rd_val[7:0] = i_thr_r;
      ddcpc_pkg::IDX_OVR_PERIOD: rd_val[2:0] = per_exp_r;
      ddcpc_pkg::IDX_SRC_CTRL:   rd_val[0]   = src_r;
      ddcpc_pkg::IDX_PRESET_SEL: rd_val[2:0] = pidx_r;
      ddcpc_pkg::IDX_RDIV:       rd_val[15:0] = rdiv_r;
      ddcpc_pkg::IDX_IRQ_STATUS: rd_val[ddcpc_pkg::IRQ_W-1:0] = sts_r;
      ddcpc_pkg::IDX_IRQ_MASK:   rd_val[ddcpc_pkg::IRQ_W-1:0] = mask_r;
      ddcpc_pkg::IDX_PRESET_WR:  rd_val[2:0] = wr_sel_r;
      ddcpc_pkg::IDX_ACTIVE:     rd_val[2:0] = act_r;
      default: begin
        if (ar_idx[9:3] == ddcpc_pkg::IDX_FREQ_BASE[9:3]) begin
          rd_val = shadow_r[ar_idx[2:0]].freq;
        end else if (ar_idx[9:3] == ddcpc_pkg::IDX_PHASE_BASE[9:3]) begin
          rd_val[15:0] = shadow_r[ar_idx[2:0]].phase;
        end else if (ar_idx[9:3] == ddcpc_pkg::IDX_DELAY_BASE[9:3]) begin
          rd_val[7:0] = shadow_r[ar_idx[2:0]].delay;
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ddcpc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? ddcpc_pkg::RESP_OKAY : ddcpc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== dv/ddcpc_props.sv ====
/*
  Concurrent checks on the ports of the configuration bank.
  Assumes one clock and the top's synchronous active-low reset.
*/
`timescale 1ns/100ps
module ddcpc_props (
  input wire logic                     aclk,                  // clock
  input wire logic                     aresetn,               // sync reset, low
  input wire logic                     s_axi_awvalid,         // aw valid
  input wire logic                     s_axi_awready,         // aw ready
  input wire logic                     s_axi_wvalid,          // w valid
  input wire logic                     s_axi_wready,          // w ready
  input wire logic [1:0]               s_axi_bresp,           // b response
  input wire logic                     s_axi_bvalid,          // b valid
  input wire logic                     s_axi_bready,          // b ready
  input wire logic                     s_axi_arvalid,         // ar valid
  input wire logic                     s_axi_arready,         // ar ready
  input wire logic [31:0]              s_axi_rdata,           // read data
  input wire logic                     s_axi_rvalid,          // r valid
  input wire logic                     s_axi_rready,          // r ready
  input wire logic                     smp_valid,             // sample strobe
  input wire ddcpc_pkg::ddcpc_sample_t smp_in,                // samples in
  input wire ddcpc_pkg::ddcpc_sample_t smp_out,               // samples out
  input wire logic [1:0]               overrange_flags,       // flags
  input wire logic                     smp_out_valid,         // output strobe
  input wire logic [2:0]               active_preset,         // preset in use
  input wire ddcpc_pkg::ddcpc_preset_t preset_cfg,            // preset values
  input wire logic [15:0]              rational_step_divisor  // divisor
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////////
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  wr_answer_a: assert property (wr_taken |=> wr_answer)
    else $error("late write response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata not held");
  rst_vals_a: assert property ($rose(aresetn) |-> rational_step_divisor == 16'h0000 && active_preset == 3'h0)
    else $error("bad reset value");
  smp_pass_a: assert property (smp_valid |=> smp_out_valid && smp_out == $past(smp_in))
    else $error("sample lost");
  q_flag_a: assert property ($rose(overrange_flags[1]) |-> smp_out_valid)
    else $error("stray q flag");
  i_flag_a: assert property ($rose(overrange_flags[0]) |-> smp_out_valid)
    else $error("stray i flag");
  phase_low_a: assert property (preset_cfg.phase_word[15:0] == 16'h0000)
    else $error("phase not in upper half");
endmodule

bind ddcpc_top ddcpc_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .smp_valid, .smp_in, .smp_out, .overrange_flags, .smp_out_valid, .active_preset,
  .preset_cfg, .rational_step_divisor
);

// ==== dv/ddcpc_host_model.sv ====
/*
  Host side: drives the preset pins and works out the divisor.
  Assumes pins change just after a clock edge.
*/
`timescale 1ns/100ps
module ddcpc_host_model #(
  parameter int FS_KHZ   = 3072000, // sample rate
  parameter int STEP_KHZ = 10       // wanted frequency step
) (
  input wire logic  aclk, // clock
  input wire logic [2:0] want, // preset wanted on the pins
  output logic [2:0] pins, // preset select pins
  output logic [15:0] rdiv // divisor to program
);
  // Parameters keep the quotient whole and at or below 8192.
  assign rdiv = 16'(FS_KHZ / STEP_KHZ / 128);
  always @(posedge aclk) begin
    pins <= want;
  end
endmodule

// ==== dv/ddc_preset_overrange_config_bench.sv ====
/*
  Self-checking bench: AXI4-Lite tasks, samples and preset pins.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/100ps
module ddc_preset_overrange_config_bench;
  logic                     aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic                     s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, smp_valid = 1'b0;
  logic [11:0]              s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]              s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]               s_axi_wstrb = 4'hf;
  logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, smp_out_valid, irq;
  logic [1:0]               s_axi_bresp, s_axi_rresp, overrange_flags, r;
  logic [2:0]               active_preset, preset_select_pins, want = 3'h0;
  logic [15:0]              rational_step_divisor, rdiv;
  logic [14:0]              v;
  ddcpc_pkg::ddcpc_sample_t smp_in = '0, smp_out;
  ddcpc_pkg::ddcpc_preset_t preset_cfg;
  int                       miscompares = 0, total_checks = 0, ci, cq;
  logic [7:0]               thr [2] = '{8'hab, 8'h40};
  logic [2:0]               exps [3] = '{3'h0, 3'h2, 3'h7};

  always #5 aclk = ~aclk;

  ddcpc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .preset_select_pins, .smp_valid,
    .smp_in, .smp_out, .overrange_flags, .smp_out_valid, .active_preset, .preset_cfg, .rational_step_divisor, .irq);
  ddcpc_host_model host (.aclk, .want, .pins(preset_select_pins), .rdiv);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 72'(s_axi_bresp), 72'(ddcpc_pkg::RESP_OKAY));
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] rdd, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [9:0] idx, input logic [31:0] exp, input string nm);
    rd(idx, d, r);
    chk(nm, 72'(d), 72'(exp));
  endtask

  // One marked sample, then zeros; counts flagged outputs.
  task automatic run(input logic [14:0] i, input logic [14:0] q);
    @(posedge aclk);
    smp_in <= {i, q};
    ci = 0;
    cq = 0;
    repeat (140) begin
      @(posedge aclk);
      smp_in <= '0;
      if (smp_out_valid === 1'b1) begin
        ci += int'(overrange_flags[0]);
        cq += int'(overrange_flags[1]);
      end
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    close_out;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    smp_valid <= 1'b1;
    rc(ddcpc_pkg::IDX_Q_THRESH, 32'hab, "q_thresh_rst");
    rc(ddcpc_pkg::IDX_OVR_PERIOD, 32'h0, "period_rst");
    rc(ddcpc_pkg::IDX_SRC_CTRL, 32'h0, "source_rst");
    rc(ddcpc_pkg::IDX_PRESET_SEL, 32'h0, "index_rst");
    rc(ddcpc_pkg::IDX_RDIV, 32'h0, "rdiv_rst");
    rd(10'h3ff, d, r);
    chk("unmapped_resp", 72'(r), 72'(ddcpc_pkg::RESP_SLVERR));
    chk("cfg_rst", preset_cfg, {ddcpc_pkg::RST_FREQ, ddcpc_pkg::RST_PHASE, 16'h0, ddcpc_pkg::RST_DELAY});
    foreach (thr[k]) begin
      wr(ddcpc_pkg::IDX_Q_THRESH, 32'(thr[k]));
      v = {1'b0, thr[k], 6'h0};
      run(15'h0, v - 15'h1);
      chk("q_below", 72'(cq), 72'(0));
      run(15'h0, v);
      chk("q_at", 72'(cq), 72'(1));
      run(15'h0, 15'h0 - v);
      chk("q_neg", 72'(cq), 72'(1));
    end
    run(15'h3c7f, 15'h0);
    chk("i_below", 72'(ci), 72'(0));
    run(15'h3c80, 15'h0);
    chk("i_at", 72'(ci), 72'(1));
    chk("irq_masked", 72'(irq), 72'(0));
    rc(ddcpc_pkg::IDX_IRQ_STATUS, 32'h3, "status_set");
    rc(ddcpc_pkg::IDX_IRQ_STATUS, 32'h0, "status_clr");
    foreach (exps[k]) begin
      // No link encoder runs here, so the period may change.
      wr(ddcpc_pkg::IDX_OVR_PERIOD, 32'(exps[k]));
      run(15'h0, 15'h3000);
      chk("q_period", 72'(cq), 72'(1 << exps[k]));
    end
    wr(ddcpc_pkg::IDX_IRQ_MASK, 32'h2);
    run(15'h0, 15'h3000);
    chk("irq_raised", 72'(irq), 72'(1));
    rc(ddcpc_pkg::IDX_IRQ_STATUS, 32'h2, "status_q");
    @(posedge aclk);
    chk("irq_cleared", 72'(irq), 72'(0));
    wr(ddcpc_pkg::IDX_RDIV, 32'(rdiv));
    rc(ddcpc_pkg::IDX_RDIV, 32'(rdiv), "rdiv_rb");
    chk("rdiv_port", 72'(rational_step_divisor), 72'(rdiv));
    wr(ddcpc_pkg::IDX_FREQ_BASE + 10'h3, 32'h12345678);
    wr(ddcpc_pkg::IDX_PHASE_BASE + 10'h3, 32'hbeef);
    wr(ddcpc_pkg::IDX_DELAY_BASE + 10'h3, 32'h21);
    want <= 3'h5;
    repeat (6) @(posedge aclk);
    chk("pin_preset", 72'(active_preset), 72'h5);
    chk("cfg_pin", preset_cfg, {ddcpc_pkg::RST_FREQ, ddcpc_pkg::RST_PHASE, 16'h0, ddcpc_pkg::RST_DELAY});
    wr(ddcpc_pkg::IDX_PRESET_SEL, 32'h3);
    repeat (4) @(posedge aclk);
    chk("index_ignored", 72'(active_preset), 72'h5);
    wr(ddcpc_pkg::IDX_SRC_CTRL, 32'h1);
    want <= 3'h6;
    repeat (6) @(posedge aclk);
    chk("reg_preset", 72'(active_preset), 72'h3);
    chk("cfg_reg", preset_cfg, {32'h12345678, 32'hbeef0000, 8'h21});
    wr(ddcpc_pkg::IDX_SRC_CTRL, 32'h0);
    repeat (6) @(posedge aclk);
    chk("pins_again", 72'(active_preset), 72'h6);
    close_out;
  end
endmodule
